// file: src/wwd_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "wwd_params.svh"

// Summary of operation
// - counter drops by one every 4096 times two-power-select bus clocks.
// - select 00,01,10,11 multiplies the 4096 base by 1,2,4,8.
// - counter runs and wraps whenever not frozen, armed or not.
// - arm bit off after reset, set by writing one, cleared only by reset.
// - armed, counter falling 0x40 to 0x3F requests system reset.
// - armed, writing counter with top bit zero requests system reset.
// - armed, reload while counter above window requests system reset.
// - window value is software held and bounds the reload window.
// - early-warning flag sets as counter reaches 0x40, enable or not.
// - with warning enable, interrupt rises as counter reaches 0x40.
// - warning enable set by writing one; only reset clears it.
// - warning flag cleared by writing zero; writing one does nothing.
// - debug freeze input halts counting while in debug mode.
// - gated clock stops counting; module reset restores all watchdog state, not read data, ack or freeze sync.
module wwd_top
(
  // clock and resets
  input wire logic I_CLK,
  input wire logic I_RSTN,
  input wire logic I_MOD_RSTN,
  // debug freeze from debug module
  input wire logic I_DBG_FREEZE,
  // register port
  input wire logic I_SEL,
  input wire logic I_WR,
  input wire logic [31:0] I_ADDR,
  input wire logic [15:0] I_WDATA,
  output logic [15:0] O_RDATA,
  output logic O_ACK,
  // system outputs
  output logic O_RST_REQ,
  output logic O_IRQ
);

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic [2:0] hi_mask(input logic [1:0] s);
    hi_mask = 3'(({1'b0, 3'h1} << s) - 4'h1);
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic [6:0] cnt_reg;
  logic [6:0] cnt_next;
  logic [`WWD_PRE_W-1:0] pre_reg;
  logic [`WWD_PRE_W-1:0] pre_next;
  wwd_pkg::wwd_cfg_t cfg_reg;
  wwd_pkg::wwd_cfg_t cfg_next;
  logic arm_reg;
  logic arm_next;
  logic flag_reg;
  logic flag_next;
  logic rst_reg;
  logic rst_next;
  logic irq_reg;
  logic irq_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic ack_reg;
  logic dbg_s1_reg;
  logic dbg_s2_reg;
  logic dbg_s3_reg;
  logic frz_reg;
  logic frz_next;

  // ****************************************
  // register access decode
  // ****************************************
  wwd_pkg::wwd_req_t req;
  wire logic hit_ctrl;
  wire logic hit_cfg;
  wire logic hit_stat;
  wire logic wr_ctrl;
  wire logic wr_cfg;
  wire logic wr_stat;
  wire logic rd_any;

  assign req = '{wr: I_WR, addr: I_ADDR, wdata: I_WDATA};
  assign hit_ctrl = req.addr == `WWD_ADDR_CTRL;
  assign hit_cfg = req.addr == `WWD_ADDR_CFG;
  assign hit_stat = req.addr == `WWD_ADDR_STAT;
  assign wr_ctrl = I_SEL & req.wr & hit_ctrl;
  assign wr_cfg = I_SEL & req.wr & hit_cfg;
  assign wr_stat = I_SEL & req.wr & hit_stat;
  assign rd_any = I_SEL & ~req.wr;

  // ****************************************
  // prescaler and count tick
  // ****************************************
  wire logic [2:0] sel_mask;
  wire logic base_end;
  wire logic tick;

  assign sel_mask = hi_mask(cfg_reg.div_sel);
  assign base_end = pre_reg[`WWD_PRE_BASE_MSB:0] == `WWD_PRE_BASE_END;
  assign tick = ~frz_reg & base_end &
    ((pre_reg[`WWD_PRE_W-1:`WWD_PRE_BASE_MSB+1] & sel_mask) == sel_mask);
  assign pre_next = frz_reg ? pre_reg :
    `WWD_PRE_W'(pre_reg + `WWD_PRE_W'(1));

  // ****************************************
  // counter, arm and reset causes
  // ****************************************
  wire logic fall_cause;
  wire logic soft_cause;
  wire logic win_cause;

  // free running, wraps 0x00 to 0x7f
  assign cnt_next = wr_ctrl ? req.wdata[`WWD_CNT_MSB:0] :
    tick ? 7'(cnt_reg - `WWD_CNT_ONE) : cnt_reg;
  assign arm_next = arm_reg | (wr_ctrl & req.wdata[`WWD_ARM_BIT]);
  assign fall_cause = tick & ~wr_ctrl & (cnt_reg == `WWD_CNT_WARN);
  assign soft_cause = wr_ctrl & ~req.wdata[`WWD_TOP_BIT];
  assign win_cause = wr_ctrl & (cnt_reg > cfg_reg.window);
  // one pulse per request
  assign rst_next = arm_next & (fall_cause | soft_cause | win_cause) &
    ~rst_reg;

  // ****************************************
  // configuration and early warning
  // ****************************************
  wire logic warn_set;
  wire logic warn_clr;

  // one driver for the whole configuration word
  assign cfg_next = '{
    ewi_en: cfg_reg.ewi_en | (wr_cfg & req.wdata[`WWD_EWI_BIT]),
    div_sel: wr_cfg ? req.wdata[`WWD_SEL_MSB:`WWD_SEL_LSB] : cfg_reg.div_sel,
    window: wr_cfg ? req.wdata[`WWD_CNT_MSB:0] : cfg_reg.window
  };
  assign warn_set = tick & ~wr_ctrl & (cnt_reg == `WWD_CNT_PREWARN);
  assign warn_clr = wr_stat & ~req.wdata[`WWD_FLAG_BIT];
  // set wins over clear
  assign flag_next = warn_set | (flag_reg & ~warn_clr);
  assign irq_next = flag_next & cfg_next.ewi_en;

  // ****************************************
  // read data
  // ****************************************
  wire logic [15:0] ctrl_view;
  wire logic [15:0] cfg_view;
  wire logic [15:0] stat_view;

  assign ctrl_view = {8'h00, arm_reg, cnt_reg};
  assign cfg_view = {6'h00, cfg_reg};
  assign stat_view = {15'h0000, flag_reg};
  assign rdata_next = ~rd_any ? rdata_reg :
    hit_ctrl ? ctrl_view :
    hit_cfg ? cfg_view :
    hit_stat ? stat_view : 16'h0000;

  // ****************************************
  // debug freeze input synchroniser
  // ****************************************
  assign frz_next = (dbg_s2_reg == dbg_s3_reg) ? dbg_s3_reg : frz_reg;

  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      dbg_s1_reg <= 1'b0;
      dbg_s2_reg <= 1'b0;
      dbg_s3_reg <= 1'b0;
      frz_reg <= 1'b0;
    end
    else
    begin
      dbg_s1_reg <= I_DBG_FREEZE;
      dbg_s2_reg <= dbg_s1_reg;
      dbg_s3_reg <= dbg_s2_reg;
      frz_reg <= frz_next;
    end
  end

  // ****************************************
  // watchdog state registers
  // ****************************************
  // module clock gating simply stops every edge here
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      cnt_reg <= `WWD_CNT_RST;
      pre_reg <= '0;
      cfg_reg <= '{1'b0, `WWD_SEL_RST, `WWD_WIN_RST};
      arm_reg <= 1'b0;
      flag_reg <= 1'b0;
      rst_reg <= 1'b0;
      irq_reg <= 1'b0;
    end
    else if (!I_MOD_RSTN)
    begin
      cnt_reg <= `WWD_CNT_RST;
      pre_reg <= '0;
      cfg_reg <= '{1'b0, `WWD_SEL_RST, `WWD_WIN_RST};
      arm_reg <= 1'b0;
      flag_reg <= 1'b0;
      rst_reg <= 1'b0;
      irq_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      pre_reg <= pre_next;
      cfg_reg <= cfg_next;
      arm_reg <= arm_next;
      flag_reg <= flag_next;
      rst_reg <= rst_next;
      irq_reg <= irq_next;
    end
  end

  // ****************************************
  // register port answer
  // ****************************************
  always_ff @(posedge I_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      rdata_reg <= 16'h0000;
      ack_reg <= 1'b0;
    end
    else
    begin
      rdata_reg <= rdata_next;
      ack_reg <= I_SEL;
    end
  end

  assign O_RDATA = rdata_reg;
  assign O_ACK = ack_reg;
  assign O_RST_REQ = rst_reg;
  assign O_IRQ = irq_reg;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RSTN || !I_MOD_RSTN);

  a_cnt_hold_idle:
    assert property (!tick && !wr_ctrl |=> $stable(cnt_reg))
    else $error("counter moved without a tick");

  a_tick_base_end:
    assert property (tick |-> base_end &&
      (pre_reg[`WWD_PRE_BASE_MSB+1] || cfg_reg.div_sel == 2'h0) &&
      (pre_reg[`WWD_PRE_BASE_MSB+2] || cfg_reg.div_sel < 2'h2) &&
      (pre_reg[`WWD_PRE_BASE_MSB+3] || cfg_reg.div_sel < 2'h3))
    else $error("tick off the divider boundary");

  a_cnt_free_run:
    assert property (tick && !wr_ctrl && I_MOD_RSTN |=>
      cnt_reg == 7'($past(cnt_reg) - `WWD_CNT_ONE))
    else $error("counter did not decrement on tick");

  a_arm_sticky:
    assert property (arm_reg |=> arm_reg)
    else $error("arm bit cleared by software");

  a_fall_reset:
    assert property (arm_reg && fall_cause && !rst_reg |=> O_RST_REQ)
    else $error("no reset on fall to 0x3f");

  a_soft_reset:
    assert property (arm_reg && soft_cause && !rst_reg |=> O_RST_REQ)
    else $error("no reset on top bit write");

  a_window_reset:
    assert property (arm_reg && wr_ctrl && cnt_reg > cfg_reg.window &&
      !rst_reg |=> O_RST_REQ)
    else $error("no reset on early reload");

  a_window_quiet:
    assert property (arm_reg && wr_ctrl && req.wdata[`WWD_TOP_BIT] &&
      cnt_reg <= cfg_reg.window && !fall_cause |=> !O_RST_REQ)
    else $error("reset on reload inside window");

  a_flag_set:
    assert property (warn_set |=> flag_reg && cnt_reg == `WWD_CNT_WARN)
    else $error("warning flag not set at 0x40");

  a_irq_follow:
    assert property (flag_reg && cfg_reg.ewi_en |-> O_IRQ)
    else $error("irq missing with flag and enable");

  a_ewi_sticky:
    assert property (cfg_reg.ewi_en |=> cfg_reg.ewi_en)
    else $error("warning enable cleared");

  a_flag_w1_keep:
    assert property (flag_reg && wr_stat && req.wdata[`WWD_FLAG_BIT]
      |=> flag_reg)
    else $error("flag cleared by writing one");

  a_frz_halt:
    assert property (frz_reg |=> $stable(pre_reg))
    else $error("prescaler ran while frozen");

  a_rst_pulse:
    assert property (O_RST_REQ |=> !O_RST_REQ)
    else $error("reset request longer than one cycle");

endmodule
`default_nettype wire

// file: src/wwd_params.svh
`ifndef WWD_PARAMS_SVH
`define WWD_PARAMS_SVH

// register byte addresses
`define WWD_ADDR_CTRL 32'h40002c00
`define WWD_ADDR_CFG 32'h40002c04
`define WWD_ADDR_STAT 32'h40002c08

// reset values
`define WWD_CNT_RST 7'h7f
`define WWD_WIN_RST 7'h7f
`define WWD_SEL_RST 2'h0

// field positions
`define WWD_ARM_BIT 7
`define WWD_TOP_BIT 6
`define WWD_CNT_MSB 6
`define WWD_EWI_BIT 9
`define WWD_SEL_MSB 8
`define WWD_SEL_LSB 7
`define WWD_FLAG_BIT 0

// counter marks
`define WWD_CNT_WARN 7'h40
`define WWD_CNT_PREWARN 7'h41
`define WWD_CNT_ONE 7'h01

// prescaler: 4096 base, up to 8 extra
`define WWD_PRE_W 15
`define WWD_PRE_BASE_MSB 11
`define WWD_PRE_BASE_END 12'hfff

`endif

// file: src/wwd_pkg.sv
package wwd_pkg;

  // configuration register contents
  typedef struct packed {
    logic ewi_en;
    logic [1:0] div_sel;
    logic [6:0] window;
  } wwd_cfg_t;

  // register access request
  typedef struct packed {
    logic wr;
    logic [31:0] addr;
    logic [15:0] wdata;
  } wwd_req_t;

endpackage

// file: tb/wwd_top_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "wwd_params.svh"

// ****************************************
// register-port bench
// ****************************************
module wwd_top_test;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic mrstn = 1'b1;
  logic frz = 1'b0;
  logic sel = 1'b0;
  logic wr = 1'b0;
  logic [31:0] addr = 32'h0;
  logic [15:0] wd = 16'h0;
  logic [15:0] rd;
  logic ack;
  logic rreq;
  logic irq;
  logic [15:0] q;
  logic [15:0] v;
  logic pls;
  int n_errors = 0;
  int samples_checked = 0;
  int n;

  always #2.5 clk = ~clk;

  wwd_top wwd_top_inst (.I_CLK(clk), .I_RSTN(rstn), .I_MOD_RSTN(mrstn),
    .I_DBG_FREEZE(frz), .I_SEL(sel), .I_WR(wr), .I_ADDR(addr),
    .I_WDATA(wd), .O_RDATA(rd), .O_ACK(ack), .O_RST_REQ(rreq),
    .O_IRQ(irq));

  // ****************************************
  // compares and accesses
  // ****************************************
  task chk16(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH t=%0t reg got %h exp %h", $time, g, e);
    end
  endtask

  task chk1(input logic g, input logic e);
    samples_checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH t=%0t bit got %b exp %b", $time, g, e);
    end
  endtask

  task chkn(input int g, input int e);
    samples_checked++;
    if (g != e)
    begin
      n_errors++;
      $display("MISMATCH t=%0t cycles got %0d exp %0d", $time, g, e);
    end
  endtask

  // one access; ack, data and reset pulse sampled in the ack cycle
  task acc(input logic w, input logic [31:0] a, input logic [15:0] d);
    @(negedge clk);
    sel = 1'b1;
    wr = w;
    addr = a;
    wd = d;
    @(negedge clk);
    sel = 1'b0;
    q = rd;
    pls = rreq;
    chk1(ack, 1'b1);
  endtask

  task rdc(input logic [31:0] a, input logic [15:0] e);
    acc(1'b0, a, 16'h0);
    chk16(q, e);
  endtask

  task wrt(input logic [31:0] a, input logic [15:0] d, input logic p);
    acc(1'b1, a, d);
    chk1(pls, p);
  endtask

  // negedges until the next reset request, bounded
  task wrst(output int k);
    k = 0;
    do
    begin
      @(negedge clk);
      k++;
    end
    while (rreq !== 1'b1 && k < 40000);
  endtask

  task finish_test;
    if (n_errors == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ****************************************
  // watchdog
  // ****************************************
  initial
  begin
    repeat (90000) @(posedge clk);
    n_errors++;
    finish_test;
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (20) @(negedge clk);
    rstn = 1'b1;
    rdc(`WWD_ADDR_CTRL, 16'h007f);
    rdc(`WWD_ADDR_CFG, 16'h007f);
    rdc(`WWD_ADDR_STAT, 16'h0000);
    rdc(32'h40002c0c, 16'h0000);
    repeat (4096) @(negedge clk);
    rdc(`WWD_ADDR_CTRL, 16'h007e);
    frz = 1'b1;
    repeat (8) @(negedge clk);
    acc(1'b0, `WWD_ADDR_CTRL, 16'h0);
    v = q;
    repeat (5000) @(negedge clk);
    rdc(`WWD_ADDR_CTRL, v);
    frz = 1'b0;
    // disarmed writes request no reset; armed early reloads and top-bit-zero writes do
    wrt(`WWD_ADDR_CTRL, 16'h0045, 1'b0);
    rdc(`WWD_ADDR_CTRL, 16'h0045);
    wrt(`WWD_ADDR_CTRL, 16'h0030, 1'b0);
    wrt(`WWD_ADDR_CFG, 16'h0050, 1'b0);
    wrt(`WWD_ADDR_CTRL, 16'h00c5, 1'b0);
    wrt(`WWD_ADDR_CTRL, 16'h0045, 1'b0);
    rdc(`WWD_ADDR_CTRL, 16'h00c5);
    wrt(`WWD_ADDR_CFG, 16'h0040, 1'b0);
    rdc(`WWD_ADDR_CFG, 16'h0040);
    wrt(`WWD_ADDR_CTRL, 16'h00c5, 1'b1);
    wrt(`WWD_ADDR_CFG, 16'h007f, 1'b0);
    wrt(`WWD_ADDR_CTRL, 16'h00bf, 1'b1);
    @(negedge clk);
    chk1(rreq, 1'b0);
    // module reset zeroes the prescaler, then time each divider setting
    mrstn = 1'b0;
    @(negedge clk);
    mrstn = 1'b1;
    for (int s = 3; s >= 0; s--)
    begin
      wrt(`WWD_ADDR_CFG, {7'h00, 2'(s), 7'h7f}, 1'b0);
      wrt(`WWD_ADDR_CTRL, (s == 0) ? 16'h00c1 : 16'h00c0, 1'b0);
      wrst(n);
      chkn(n + 4, (s == 0) ? 8192 : (4096 << s));
    end
    rdc(`WWD_ADDR_STAT, 16'h0001);
    chk1(irq, 1'b0);
    wrt(`WWD_ADDR_CFG, 16'h027f, 1'b0);
    rdc(`WWD_ADDR_CFG, 16'h027f);
    chk1(irq, 1'b1);
    wrt(`WWD_ADDR_STAT, 16'h0001, 1'b0);
    rdc(`WWD_ADDR_STAT, 16'h0001);
    wrt(`WWD_ADDR_STAT, 16'h0000, 1'b0);
    rdc(`WWD_ADDR_STAT, 16'h0000);
    chk1(irq, 1'b0);
    wrt(`WWD_ADDR_CFG, 16'h007f, 1'b0);
    rdc(`WWD_ADDR_CFG, 16'h027f);
    mrstn = 1'b0;
    @(negedge clk);
    mrstn = 1'b1;
    rdc(`WWD_ADDR_CTRL, 16'h007f);
    rdc(`WWD_ADDR_CFG, 16'h007f);
    rdc(`WWD_ADDR_STAT, 16'h0000);
    finish_test;
  end
endmodule

`default_nettype wire
